//--- pkg/aisi_pkg.sv
/*
  shared constants and carriers for the axis io status and interrupt block:
  register offsets, field positions, reset values and the valid-bit maps of the
  two cause words. assumes one axis per block instance and a 32-bit axi4-lite bus.
*/
package aisi_pkg;

  // ----------------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------------
  localparam int ADDR_W = 8;                    // byte address width seen by the slave
  localparam int DATA_W = 32;                   // axi data width

  // ----------------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_TERM_STATE = 8'h00;  // motion_terminal_state, ro
  localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 8'h04;  // event_cause_mask, rw
  localparam logic [ADDR_W-1:0] OFF_FAULT_FLAGS = 8'h08; // fault_cause_flags, read-clear
  localparam logic [ADDR_W-1:0] OFF_EVENT_FLAGS = 8'h0c; // event_cause_flags, read-clear
  localparam logic [ADDR_W-1:0] OFF_IRQ_CTRL = 8'h10;    // interrupt_control, rw
  localparam logic [ADDR_W-1:0] OFF_POLARITY = 8'h14;    // terminal_polarity, rw

  // ----------------------------------------------------------------------------
  // axi response codes
  // ----------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------------
  // terminal status word bit positions
  // ----------------------------------------------------------------------------
  localparam int TS_READY = 0;
  localparam int TS_FAULT = 1;
  localparam int TS_POS_LIMIT = 2;
  localparam int TS_NEG_LIMIT = 3;
  localparam int TS_HOME = 4;
  localparam int TS_DIRECTION = 5;
  localparam int TS_ESTOP = 6;
  localparam int TS_POS_CHANGE = 7;
  localparam int TS_DEV_CLEAR = 8;
  localparam int TS_INDEX = 9;
  localparam int TS_RESERVED = 10;              // always reads 0
  localparam int TS_LATCH = 11;
  localparam int TS_SLOWDOWN = 12;
  localparam int TS_IN_POSITION = 13;
  localparam int TS_SERVO_EN = 14;
  localparam logic [15:0] TS_VALID = 16'h7bff;  // bits 0..9 and 11..14
  localparam logic [15:0] POLARITY_RESET = 16'hffff; // 1 = active high for every signal
  localparam int POL_SYNC_START = 15;           // polarity bit used for the sync start pin

  // ----------------------------------------------------------------------------
  // cause word layouts
  // ----------------------------------------------------------------------------
  localparam logic [31:0] FAULT_VALID = 32'h0003f4eb; // defined error cause bits
  localparam logic [31:0] EVENT_VALID = 32'h8009dcf7; // defined event cause bits
  localparam logic [31:0] MASK_VALID = 32'h0005dcf7;  // writable event mask bits
  localparam int EV_HOME_ON = 15;
  localparam int EV_SLOWDOWN_ON = 16;
  localparam int MASK_SYNC_START = 18;          // mask position of sync start enable
  localparam int EV_SYNC_START = 19;            // cause position of sync start
  localparam int EV_AXIS_STOP = 31;             // unmaskable axis stop cause
  localparam logic [31:0] EVENT_MASK_RESET = 32'h00000000;

  // ----------------------------------------------------------------------------
  // interrupt control register fields
  // ----------------------------------------------------------------------------
  localparam int CTRL_GLOBAL_EN = 0;
  localparam int CTRL_STOP_EN = 1;
  localparam int CTRL_STOP_FINAL_ONLY = 2;
  localparam int CTRL_SERVO_EN = 3;
  localparam int CTRL_W = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  // ----------------------------------------------------------------------------
  // terminal pins from the machine side, all asynchronous to clock_i
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic sync_start;
    logic in_position;
    logic slowdown;
    logic latch;
    logic index;
    logic pos_change;
    logic estop;
    logic home;
    logic neg_limit;
    logic pos_limit;
    logic fault;
    logic ready;
  } aisi_term_s;

  localparam int TERM_W = 12;                   // width of aisi_term_s

endpackage : aisi_pkg

//--- verilog/aisi_sync_bits.sv
/*
  two-flop synchroniser for a bundle of independent level signals.
  assumes each bit is a slow level; no multi-bit coherence is promised.
*/
module aisi_sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------------------
  // flop chain
  // ----------------------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg; // first stage, read only by the second stage
  logic [WIDTH-1:0] sync_reg; // second stage, safe to use

  // both stages clear together under reset
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // aisi_sync_bits

//--- verilog/aisi_top.sv
/*
  axis io status and interrupt block: one axis worth of terminal snapshot,
  error and event cause words with read-clear, event mask and a global gate
  onto one interrupt request, all behind an axi4-lite slave.
  assumes event and stop pulses come from motion logic on clock_i, and that
  terminal pins are asynchronous and slow compared to the 40 ns clock.
*/
// How it works
// - bits 0-4: ready, fault, limits, home
// - bits 5-9: direction, estop, change, clear, index
// - bit 10 zero; 11-14 latch, slowdown, inposition, servo
// - status bits other than servo mean active after polarity applied
// - global enable gates the interrupt request
// - two separate 32-bit cause words per axis
// - event cause interrupts only when mask bit set
// - error causes always interrupt, never masked
// - event bit 31 axis stop, unmaskable
// - reading a cause word returns it, clears it
// - error bits 0,1,3,5,6,7 defined, 2,4 zero
// - error bits 10,12,13 defined, 8,9,11 zero
// - error bits 14-17 defined, 18-31 zero
// - event bits 0-2: stop, continue, preregister empty
// - event bits 4-7 ramp edges, bit 3 zero
// - event bits 10,11,12,14 step, compare, trigger, latch
// - event bits 15,16,19 home, slowdown, sync start
// - mask bit 18 enables sync start cause
// - axis stop raised for every stop when enabled
// - final-only setting limits stop to last command
module aisi_top
  import aisi_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  // axi4-lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [aisi_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [aisi_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [aisi_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [aisi_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // terminals and motion logic
  input wire aisi_pkg::aisi_term_s term_pins_i,
  input wire logic direction_i,
  input wire logic deviation_clear_i,
  input wire logic [31:0] fault_set_i,
  input wire logic [31:0] event_set_i,
  input wire logic axis_stop_i,
  input wire logic last_command_i,
  output logic servo_enable_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  aisi_term_s term_sync;            // synchronised pin levels
  logic [15:0] term_state_reg;      // terminal snapshot
  logic [15:0] term_state_next;
  logic [15:0] polarity_reg;        // 1 = signal active high
  logic [31:0] event_mask_reg;      // event cause mask
  logic [31:0] fault_flags_reg;     // sticky error causes
  logic [31:0] fault_flags_next;
  logic [31:0] event_flags_reg;     // sticky event causes
  logic [31:0] event_flags_next;
  logic [CTRL_W-1:0] ctrl_reg;      // global enable, stop controls, servo
  logic sync_active_reg;            // previous sync start activity, for edges
  logic sync_active;
  logic [31:0] fault_set;           // error causes arriving this cycle
  logic [31:0] event_set;           // event causes arriving this cycle
  logic [31:0] eff_mask;            // mask as seen by the interrupt request
  logic stop_raise;                 // axis stop cause this cycle
  // bus side
  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;                    // both address and data held, response free
  logic rd_fire;                    // read address handshake
  logic clr_fault;                  // read-clear strobe for the error word
  logic clr_event;                  // read-clear strobe for the event word

  // ----------------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------------
  aisi_sync_bits #(
    .WIDTH(TERM_W)
  ) u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(term_pins_i),
    .sync_o(term_sync)
  );

  // ----------------------------------------------------------------------------
  // terminal snapshot
  // ----------------------------------------------------------------------------
  // raw level xnor polarity gives activity; servo reflects the control bit
  always_comb begin
    term_state_next = '0;
    term_state_next[TS_READY] = term_sync.ready ~^ polarity_reg[TS_READY];
    term_state_next[TS_FAULT] = term_sync.fault ~^ polarity_reg[TS_FAULT];
    term_state_next[TS_POS_LIMIT] = term_sync.pos_limit ~^ polarity_reg[TS_POS_LIMIT];
    term_state_next[TS_NEG_LIMIT] = term_sync.neg_limit ~^ polarity_reg[TS_NEG_LIMIT];
    term_state_next[TS_HOME] = term_sync.home ~^ polarity_reg[TS_HOME];
    term_state_next[TS_DIRECTION] = direction_i ~^ polarity_reg[TS_DIRECTION];
    term_state_next[TS_ESTOP] = term_sync.estop ~^ polarity_reg[TS_ESTOP];
    term_state_next[TS_POS_CHANGE] = term_sync.pos_change ~^ polarity_reg[TS_POS_CHANGE];
    term_state_next[TS_DEV_CLEAR] = deviation_clear_i ~^ polarity_reg[TS_DEV_CLEAR];
    term_state_next[TS_INDEX] = term_sync.index ~^ polarity_reg[TS_INDEX];
    term_state_next[TS_LATCH] = term_sync.latch ~^ polarity_reg[TS_LATCH];
    term_state_next[TS_SLOWDOWN] = term_sync.slowdown ~^ polarity_reg[TS_SLOWDOWN];
    term_state_next[TS_IN_POSITION] = term_sync.in_position ~^ polarity_reg[TS_IN_POSITION];
    term_state_next[TS_SERVO_EN] = ctrl_reg[CTRL_SERVO_EN];
    term_state_next = term_state_next & TS_VALID;
  end

  // snapshot refreshes every cycle so a read sees one cycle of lag behind the synchroniser, three behind the pins
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      term_state_reg <= '0;
      sync_active_reg <= 1'b0;
    end else begin
      term_state_reg <= term_state_next;
      sync_active_reg <= sync_active;
    end
  end

  assign sync_active = term_sync.sync_start ~^ polarity_reg[POL_SYNC_START];
  // pin level is the active state seen through the servo polarity
  assign servo_enable_o = ctrl_reg[CTRL_SERVO_EN] ~^ polarity_reg[TS_SERVO_EN];

  // ----------------------------------------------------------------------------
  // cause collection
  // ----------------------------------------------------------------------------
  // a stop raises bit 31 when stop enable is set, unless final-only is set and more commands follow
  assign stop_raise = axis_stop_i && ctrl_reg[CTRL_STOP_EN] &&
                      (!ctrl_reg[CTRL_STOP_FINAL_ONLY] || last_command_i);

  assign fault_set = fault_set_i & FAULT_VALID;

  // home, slowdown and sync start causes come from our own activity edges
  always_comb begin
    event_set = event_set_i & EVENT_VALID;
    event_set[EV_HOME_ON] = term_state_next[TS_HOME] && !term_state_reg[TS_HOME];
    event_set[EV_SLOWDOWN_ON] = term_state_next[TS_SLOWDOWN] && !term_state_reg[TS_SLOWDOWN];
    event_set[EV_SYNC_START] = sync_active && !sync_active_reg;
    event_set[EV_AXIS_STOP] = stop_raise;
  end

  // mask bit 18 steers cause bit 19; bit 31 always passes
  always_comb begin
    eff_mask = event_mask_reg & EVENT_VALID;
    eff_mask[EV_SYNC_START] = event_mask_reg[MASK_SYNC_START];
    eff_mask[EV_AXIS_STOP] = 1'b1;
  end

  // set wins over the read-clear so an event landing on the read is kept
  always_comb begin
    fault_flags_next = (fault_flags_reg & ~{32{clr_fault}}) | fault_set;
    event_flags_next = (event_flags_reg & ~{32{clr_event}}) | event_set;
  end

  // the two cause words are kept apart
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      fault_flags_reg <= '0;
      event_flags_reg <= '0;
    end else begin
      fault_flags_reg <= fault_flags_next;
      event_flags_reg <= event_flags_next;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------------------
  // errors bypass the mask; events only through it; everything behind the gate
  assign irq_o = ctrl_reg[CTRL_GLOBAL_EN] &&
                 ((|fault_flags_reg) || (|(event_flags_reg & eff_mask)));

  // ----------------------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  // address and data are captured in either order, then committed together
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // byte-lane merge for the writable registers
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // writable registers; read-only and read-clear offsets accept and ignore data
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      event_mask_reg <= EVENT_MASK_RESET;
      ctrl_reg <= CTRL_RESET;
      polarity_reg <= POLARITY_RESET;
    end else if (wr_fire) begin
      if (aw_addr_reg == OFF_EVENT_MASK) begin
        event_mask_reg <= merge_lanes(event_mask_reg, w_data_reg, w_strb_reg) & MASK_VALID;
      end
      if (aw_addr_reg == OFF_IRQ_CTRL) begin
        ctrl_reg <= CTRL_W'(merge_lanes({28'h0000000, ctrl_reg}, w_data_reg, w_strb_reg));
      end
      if (aw_addr_reg == OFF_POLARITY) begin
        polarity_reg <= 16'(merge_lanes({16'h0000, polarity_reg}, w_data_reg, w_strb_reg));
      end
    end
  end

  // write response: okay for mapped offsets, slverr for the rest
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_addr_reg <= OFF_POLARITY && aw_addr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------------------
  assign s_axi_arready = !rvalid_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign clr_fault = rd_fire && (s_axi_araddr == OFF_FAULT_FLAGS);
  assign clr_event = rd_fire && (s_axi_araddr == OFF_EVENT_FLAGS);

  // data is captured on the address edge, the same edge that clears the word
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_TERM_STATE: rdata_reg <= {16'h0000, term_state_reg};
        OFF_EVENT_MASK: rdata_reg <= event_mask_reg;
        OFF_FAULT_FLAGS: rdata_reg <= fault_flags_reg;
        OFF_EVENT_FLAGS: rdata_reg <= event_flags_reg;
        OFF_IRQ_CTRL: rdata_reg <= {28'h0000000, ctrl_reg};
        OFF_POLARITY: rdata_reg <= {16'h0000, polarity_reg};
        default: begin
          // unmapped offset answers zero with an error
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_fault_read_quiet;
    clr_fault && (fault_set == 32'h00000000);
  endsequence

  sequence s_stop_counted;
    axis_stop_i && ctrl_reg[CTRL_STOP_EN] && (!ctrl_reg[CTRL_STOP_FINAL_ONLY] || last_command_i);
  endsequence

  sequence s_stop_skipped;
    axis_stop_i && ctrl_reg[CTRL_STOP_FINAL_ONLY] && !last_command_i && !event_flags_reg[EV_AXIS_STOP];
  endsequence

  a_read_clears_fault: assert property (s_fault_read_quiet |=> fault_flags_reg == 32'h00000000)
    else $error("fault word not cleared after read");

  a_read_returns_word: assert property (s_fault_read_quiet |=> s_axi_rvalid &&
                                        s_axi_rdata == $past(fault_flags_reg))
    else $error("fault read did not return the held word");

  a_set_beats_clear: assert property (clr_event && |event_set |=>
                                      (event_flags_reg & $past(event_set)) == $past(event_set))
    else $error("event arriving on read-clear was lost");

  a_fault_unmasked: assert property (ctrl_reg[CTRL_GLOBAL_EN] && |fault_flags_reg |-> irq_o)
    else $error("error cause did not raise the request");

  a_global_gate: assert property (!ctrl_reg[CTRL_GLOBAL_EN] |-> !irq_o)
    else $error("request raised while globally disabled");

  a_mask_blocks: assert property (fault_flags_reg == 32'h00000000 &&
                                  (event_flags_reg & event_mask_reg & 32'h7ff7ffff) == 32'h00000000 &&
                                  !(event_flags_reg[EV_SYNC_START] && event_mask_reg[MASK_SYNC_START]) &&
                                  !event_flags_reg[EV_AXIS_STOP] |-> !irq_o)
    else $error("masked event raised the request");

  a_stop_counted: assert property (s_stop_counted |=> event_flags_reg[EV_AXIS_STOP] ##1
                                   (irq_o || !ctrl_reg[CTRL_GLOBAL_EN] || !event_flags_reg[EV_AXIS_STOP]))
    else $error("axis stop not flagged or not requested");

  a_stop_final_only: assert property (s_stop_skipped |=> !event_flags_reg[EV_AXIS_STOP])
    else $error("non-final command raised axis stop");

  a_reserved_zero: assert property ((fault_flags_reg & ~FAULT_VALID) == 32'h00000000 &&
                                    (event_flags_reg & ~EVENT_VALID) == 32'h00000000 &&
                                    !term_state_reg[TS_RESERVED])
    else $error("reserved status bit set");

  a_pin_active_level: assert property ($stable(polarity_reg) [*4] |->
                                       term_state_reg[TS_POS_LIMIT] ==
                                       ($past(term_pins_i.pos_limit, 3) ~^ polarity_reg[TS_POS_LIMIT]))
    else $error("limit status does not follow pin through polarity");

endmodule // aisi_top

//--- tb/aisi_host_model.sv
/* host side axi4-lite master model.
   assumes the bench runs clock_i and adds timeouts to its error count. */
module aisi_host_model
  import aisi_pkg::*;
(
  input wire logic clock_i,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  output logic s_axi_awvalid,
  output logic [aisi_pkg::ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_wvalid,
  output logic [aisi_pkg::DATA_W-1:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_bready,
  output logic s_axi_arvalid,
  output logic [aisi_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  int timeouts = 0; // answers that never came
  initial {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_bready, s_axi_arvalid, s_axi_araddr} = '0;
  initial {s_axi_rready, s_axi_wstrb} = 5'h0f; // full words only
  // write: both channels offered at once; a taken line shows the inverse so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_bready} <= {1'b1, a, 1'b1, d, 1'b1};
    for (n = 0; n < 64; n++) begin
      @(posedge clock_i);
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 64) timeouts++;
  endtask
  // read: rready held from the start until rvalid is sampled
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clock_i);
    {s_axi_arvalid, s_axi_araddr, s_axi_rready} <= {1'b1, a, 1'b1};
    for (n = 0; n < 64; n++) begin
      @(posedge clock_i);
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 64) timeouts++;
  endtask
endmodule // aisi_host_model

//--- tb/axis_io_status_and_interrupts_bench.sv
/* self-checking bench: reads are noted in a queue and checked as rvalid lands.
   assumes the host model owns every axi request signal. */
module axis_io_status_and_interrupts_bench;
  import aisi_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic reset_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, direction_i, deviation_clear_i;
  logic axis_stop_i, last_command_i, servo_enable_o, irq_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, fault_set_i, event_set_i, v, f, e;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  aisi_term_s term_pins_i, t;
  logic [33:0] exp_q[$];
  logic [15:0] ts;
  int num_errors = 0;
  int checks_done = 0;
  always #20 clock_i = ~clock_i;
  aisi_top aisi_top_i (.*);
  aisi_host_model aisi_host_model_i (.*);
  task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic close_out();
    // let the watcher see the last completed read before the verdict
    @(negedge clock_i);
    num_errors += aisi_host_model_i.timeouts;
    // a note left on the queue is a read that never completed
    if (exp_q.size() != 0) num_errors++;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // note the expected {resp, data}, then read
  task automatic rx(input logic [7:0] a, input logic [33:0] x);
    exp_q.push_back(x);
    aisi_host_model_i.rd(a);
  endtask
  task automatic pulse(input logic [31:0] fs, input logic [31:0] es, input logic st);
    @(posedge clock_i);
    {fault_set_i, event_set_i, axis_stop_i} <= {fs, es, st};
    @(posedge clock_i);
    {fault_set_i, event_set_i, axis_stop_i} <= 65'h0;
  endtask
  task automatic irq_is(input logic x);
    @(negedge clock_i);
    chk("irq", {33'h0, x}, {33'h0, irq_o});
  endtask
  // watcher: oldest note against each completed read
  always @(posedge clock_i) begin
    if (s_axi_rvalid && s_axi_rready) chk("read", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {RESP_OKAY, 32'h0}, {s_axi_bresp, 32'h0});
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    close_out();
  end
  initial begin
    {term_pins_i, direction_i, deviation_clear_i, fault_set_i, event_set_i, axis_stop_i, last_command_i} = '0;
    reset_n_i = 1'b0;
    void'($urandom(32'hddd2));
    v = $urandom;
    t = v[11:0];
    ts = {2'b0, t.in_position, t.slowdown, t.latch, 1'b0, t.index, v[13], t.pos_change, t.estop, v[12], t.home,
          t.neg_limit, t.pos_limit, t.fault, t.ready};
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rx(OFF_POLARITY, {2'h0, 32'h0000ffff});
    rx(OFF_EVENT_MASK, 34'h0);
    rx(8'h18, {RESP_SLVERR, 32'h0});
    @(posedge clock_i);
    {term_pins_i, direction_i, deviation_clear_i} <= {t, v[12], v[13]};
    repeat (4) @(posedge clock_i);
    rx(OFF_TERM_STATE, {18'h0, ts});
    aisi_host_model_i.wr(OFF_POLARITY, 32'h0);
    chk("servo", 34'h1, {33'h0, servo_enable_o});
    rx(OFF_TERM_STATE, {18'h0, ~ts & TS_VALID & ~16'h4000});
    aisi_host_model_i.wr(OFF_POLARITY, 32'h0000ffff);
    repeat (4) @(posedge clock_i);
    rx(OFF_EVENT_FLAGS, {2'h0, 32'h00098000});
    f = $urandom | 32'h1;
    pulse(f, 32'h0, 1'b0);
    irq_is(1'b0);
    aisi_host_model_i.wr(OFF_IRQ_CTRL, 32'h1);
    irq_is(1'b1);
    rx(OFF_FAULT_FLAGS, {2'h0, f & FAULT_VALID});
    rx(OFF_FAULT_FLAGS, 34'h0);
    e = $urandom | 32'h1;
    pulse(32'h0, e, 1'b0);
    irq_is(1'b0);
    aisi_host_model_i.wr(OFF_EVENT_MASK, 32'hffffffff);
    irq_is(1'b1);
    rx(OFF_EVENT_MASK, {2'h0, MASK_VALID});
    rx(OFF_EVENT_FLAGS, {2'h0, e & 32'h00005cf7});
    aisi_host_model_i.wr(OFF_EVENT_MASK, 32'h0);
    aisi_host_model_i.wr(OFF_IRQ_CTRL, 32'h7);
    pulse(32'h0, 32'h0, 1'b1);
    irq_is(1'b0);
    @(posedge clock_i);
    last_command_i <= 1'b1;
    pulse(32'h0, 32'h0, 1'b1);
    irq_is(1'b1);
    rx(OFF_EVENT_FLAGS, {2'h0, 32'h80000000});
    aisi_host_model_i.wr(OFF_IRQ_CTRL, 32'h3);
    last_command_i <= 1'b0;
    pulse(32'h0, 32'h0, 1'b1);
    rx(OFF_EVENT_FLAGS, {2'h0, 32'h80000000});
    close_out();
  end
endmodule // axis_io_status_and_interrupts_bench
